// file: hdl/timer8_pkg.sv
// Purpose: Constants and types for the 8-bit period/PWM timer.
// Assumes: Classic Wishbone slave, 32-bit data, one word per register.
// Notes: Timer clock sources arrive as asynchronous levels and are synchronised.
// Behaviour
// R1 - Control bits 7:4 pick timer clock: system, fast RC, slow RC, A0, A3, A4, comparator.
// R2 - The crystal oscillator is never offered as a timer clock source.
// R3 - Control bits 3:2 route the output waveform to pin A1, A2 or A3.
// R4 - Scale bits 6:5 pre-divide the selected clock by 1, 4, 16 or 64.
// R5 - Scaler bits 4:0 divide the prescaled clock further by value plus one.
// R6 - Counter is eight bits, counts up once per divided timer clock.
// R7 - Software loads the counter by writing count register and reads it back.
// R8 - In period mode, counter clears to zero when it reaches the bound value.
// R9 - Bound sets the period in period mode and pulse width in PWM modes.
// R10 - Period mode output is 50% square wave, period twice (bound+1) clocks.
// R11 - Period mode raises a timer interrupt event each period.
// R12 - PWM offers six-bit or eight-bit resolution.
// R13 - Control bit 1 set, scale bit 7 clear: 8-bit PWM, period 256.
// R14 - Control bit 1 set, scale bit 7 set: 6-bit PWM, period 64.
// R15 - Divided timer clock is offered to clock control as a system clock source.
// R16 - Period mode, control bit 1 clear: output toggles when counter hits bound.
// R17 - PWM counter wraps at 64 or 256; output high while count at or below bound.
// R18 - PWM output stays high all period when bound equals the resolution's top count.
package timer8_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_SCALE = 4'h4;
    localparam logic [3:0] ADDR_BOUND = 4'h8;
    localparam logic [3:0] ADDR_COUNT = 4'hC;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic ADDR_BANK_TIMER = 1'b0;
    localparam logic ADDR_BANK_IRQ = 1'b1;
    localparam int CTL_SRC_HI = 7;
    localparam int CTL_SRC_LO = 4;
    localparam int CTL_PIN_HI = 3;
    localparam int CTL_PIN_LO = 2;
    localparam int CTL_PWM_BIT = 1;
    localparam int SCL_RES6_BIT = 7;
    localparam int SCL_PRE_HI = 6;
    localparam int SCL_PRE_LO = 5;
    localparam int SCL_DIV_HI = 4;
    localparam int SCL_DIV_LO = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SCALE_RESET = 8'h00;
    localparam logic [7:0] BOUND_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] TOP_PWM8 = 8'hFF;
    localparam logic [7:0] TOP_PWM6 = 8'h3F;
    localparam int SYNC_STAGES = 3;
    // Source codes; unlisted codes stop the timer.
    localparam logic [3:0] SRC_STOP = 4'h0;
    localparam logic [3:0] SRC_SYSCLK = 4'h1;
    localparam logic [3:0] SRC_FAST_RC = 4'h2;
    localparam logic [3:0] SRC_SLOW_RC = 4'h3;
    localparam logic [3:0] SRC_PORT_A0 = 4'h4;
    localparam logic [3:0] SRC_PORT_A3 = 4'h5;
    localparam logic [3:0] SRC_PORT_A4 = 4'h6;
    localparam logic [3:0] SRC_COMPARATOR = 4'h7;
    localparam logic [1:0] PIN_NONE = 2'h0;
    localparam logic [1:0] PIN_A1 = 2'h1;
    localparam logic [1:0] PIN_A2 = 2'h2;
    localparam logic [1:0] PIN_A3 = 2'h3;

    typedef struct packed {
        logic slow_internal_rc;
        logic fast_internal_rc;
        logic port_a_bit0;
        logic port_a_bit3;
        logic port_a_bit4;
        logic comparator;
    } clk_sources_t;

    typedef struct packed {
        logic port_a_bit1;
        logic port_a_bit2;
        logic port_a_bit3;
    } pin_out_t;
endpackage

// file: hdl/timer8_period_pwm.sv
// Purpose: 8-bit up-counting timer with period and PWM modes.
// Assumes: External clock sources are slower than half of clk_i.
// Notes: Status bit 0 is the period event, cleared by writing a one.
`timescale 1ns/1ns
module timer8_period_pwm
    import timer8_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Timer clock sources
    input wire clk_sources_t src_i,
    // Outputs
    output pin_out_t pin_o,
    output pin_out_t pin_oe_o,
    output logic divided_timer_clock_o,
    output logic irq_o
);
    logic [7:0] control_r, scale_r, bound_r, count_r;
    logic status_r, mask_r;
    logic wave_r;
    logic [5:0] pre_r;
    logic [4:0] div_r;
    logic [SYNC_STAGES-1:0] sync_r [0:5];
    logic [5:0] stable_r;
    logic src_prev_r;
    logic [31:0] dat_nxt;

    // Source levels are synchronised; a change counts when stages two and three agree.
    genvar g;
    for (g = 0; g < 6; g++) begin : gen_sync
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sync_r[g] <= '0;
                stable_r[g] <= 1'b0;
            end else if (ce_i) begin
                sync_r[g] <= {sync_r[g][SYNC_STAGES-2:0], src_i[g]};
                if (sync_r[g][1] == sync_r[g][2]) begin
                    stable_r[g] <= sync_r[g][2];
                end
            end
        end
    end

    // The crystal oscillator has no input at all, so it cannot be picked.
    wire [3:0] src_sel = control_r[CTL_SRC_HI:CTL_SRC_LO]; // R1 R2
    wire is_sys = (src_sel == SRC_SYSCLK);
    wire src_level = (src_sel == SRC_SLOW_RC) ? stable_r[5] :
                     (src_sel == SRC_FAST_RC) ? stable_r[4] :
                     (src_sel == SRC_PORT_A0) ? stable_r[3] :
                     (src_sel == SRC_PORT_A3) ? stable_r[2] :
                     (src_sel == SRC_PORT_A4) ? stable_r[1] :
                     (src_sel == SRC_COMPARATOR) ? stable_r[0] : 1'b0; // R1
    wire src_tick = is_sys | (src_level & ~src_prev_r);

    wire [1:0] pre_code = scale_r[SCL_PRE_HI:SCL_PRE_LO];
    wire [5:0] pre_top = (pre_code == 2'h0) ? 6'h00 :
                         (pre_code == 2'h1) ? 6'h03 :
                         (pre_code == 2'h2) ? 6'h0F : 6'h3F; // R4
    wire pre_tick = src_tick && (pre_r == pre_top);
    wire [4:0] div_top = scale_r[SCL_DIV_HI:SCL_DIV_LO];
    wire tm_tick = pre_tick && (div_r == div_top); // R5

    wire pwm_mode = control_r[CTL_PWM_BIT];
    wire res6 = scale_r[SCL_RES6_BIT]; // R12
    wire [7:0] pwm_top = res6 ? TOP_PWM6 : TOP_PWM8; // R13 R14
    wire [7:0] count_inc = count_r + 8'h01;
    wire hit_bound = (count_r == bound_r); // R8
    wire [7:0] count_adv = pwm_mode ?
        ((count_r >= pwm_top) ? 8'h00 : count_inc) :
        (hit_bound ? 8'h00 : count_inc); // R6 R8 R17
    wire period_evt = tm_tick && !pwm_mode && hit_bound; // R11
    wire pwm_level = (count_r <= bound_r); // R17 R18
    wire wave = pwm_mode ? pwm_level : wave_r; // R9

    wire bus_req = cyc_i && stb_i && !ack_o;
    wire wr_en = bus_req && we_i && sel_i[0];
    wire bank = adr_i[4];
    wire [3:0] reg_adr = adr_i[3:0];
    wire wr_control = wr_en && bank == ADDR_BANK_TIMER && reg_adr == ADDR_CONTROL;
    wire wr_scale = wr_en && bank == ADDR_BANK_TIMER && reg_adr == ADDR_SCALE;
    wire wr_bound = wr_en && bank == ADDR_BANK_TIMER && reg_adr == ADDR_BOUND;
    wire wr_count = wr_en && bank == ADDR_BANK_TIMER && reg_adr == ADDR_COUNT;
    wire wr_status = wr_en && bank == ADDR_BANK_IRQ && reg_adr == ADDR_STATUS;
    wire wr_mask = wr_en && bank == ADDR_BANK_IRQ && reg_adr == ADDR_MASK;

    always_comb begin
        dat_nxt = 32'h0000_0000;
        if (bank == ADDR_BANK_TIMER) begin
            unique case (reg_adr)
                ADDR_CONTROL: dat_nxt[7:0] = control_r;
                ADDR_SCALE: dat_nxt[7:0] = scale_r;
                ADDR_BOUND: dat_nxt[7:0] = bound_r;
                ADDR_COUNT: dat_nxt[7:0] = count_r; // R7
                default: dat_nxt = 32'h0000_0000;
            endcase
        end else begin
            unique case (reg_adr)
                ADDR_STATUS: dat_nxt[0] = status_r;
                ADDR_MASK: dat_nxt[0] = mask_r;
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Unmapped addresses ack with zero data so a stray access never hangs the bus.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_o <= bus_req;
            dat_o <= dat_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_r <= CONTROL_RESET;
            scale_r <= SCALE_RESET;
            bound_r <= BOUND_RESET;
            mask_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_control) control_r <= dat_i[7:0];
            if (wr_scale) scale_r <= dat_i[7:0];
            if (wr_bound) bound_r <= dat_i[7:0];
            if (wr_mask) mask_r <= dat_i[0];
        end
    end

    // Prescaler and scaler reset on a count write so the new count gets a full tick.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev_r <= 1'b0;
            pre_r <= 6'h00;
            div_r <= 5'h00;
        end else if (ce_i) begin
            src_prev_r <= src_level;
            if (wr_count || pre_r > pre_top) begin
                pre_r <= 6'h00;
            end else if (src_tick) begin
                pre_r <= pre_tick ? 6'h00 : pre_r + 6'h01; // R4
            end
            if (wr_count || div_r > div_top) begin
                div_r <= 5'h00;
            end else if (pre_tick) begin
                div_r <= tm_tick ? 5'h00 : div_r + 5'h01; // R5
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= COUNT_RESET;
            wave_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_count) begin
                count_r <= dat_i[7:0]; // R7
            end else if (tm_tick) begin
                count_r <= count_adv; // R6
            end
            if (period_evt) begin
                wave_r <= ~wave_r; // R10 R16
            end
        end
    end

    // The set wins over a write-one-to-clear in the same cycle.
    wire status_nxt = period_evt | (status_r & ~(wr_status & dat_i[0])); // R11
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= 1'b0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            status_r <= status_nxt; // R11
            irq_o <= status_nxt & mask_r;
        end
    end

    wire [1:0] pin_sel = control_r[CTL_PIN_HI:CTL_PIN_LO];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= '0;
            pin_oe_o <= '0;
            divided_timer_clock_o <= 1'b0;
        end else if (ce_i) begin
            pin_o <= {3{wave}}; // R3
            pin_oe_o <= {pin_sel == PIN_A1, pin_sel == PIN_A2, pin_sel == PIN_A3}; // R3
            divided_timer_clock_o <= tm_tick; // R15
        end
    end

    period_square_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && period_evt |=> wave_r != $past(wave_r))
        else $error("period toggle missed"); // R10
    bound_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tm_tick && !wr_count && !pwm_mode && hit_bound |=> count_r == 8'h00)
        else $error("counter not cleared at bound"); // R8
    count_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tm_tick && !wr_count && !hit_bound && count_r < pwm_top
        |=> count_r == $past(count_r) + 8'h01)
        else $error("counter did not advance"); // R6
    count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !tm_tick && !wr_count |=> $stable(count_r))
        else $error("counter moved without tick"); // R6
    count_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_count |=> count_r == $past(dat_i[7:0]))
        else $error("count load lost"); // R7
    pwm6_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tm_tick && !wr_count && pwm_mode && res6 && count_r >= TOP_PWM6
        |=> count_r == 8'h00)
        else $error("6-bit wrap wrong"); // R14
    pwm_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && pwm_mode && count_r <= bound_r
        |=> pin_o.port_a_bit2)
        else $error("pwm not high"); // R17
    irq_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && period_evt |=> status_r ##1 (status_r || !ce_i || $past(wr_status)))
        else $error("status not sticky"); // R11
    pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && pin_sel == PIN_A1 |=> pin_oe_o == 3'b100)
        else $error("pin routing wrong"); // R3
    pin_none_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        ce_i && pin_sel == PIN_NONE
        |=> pin_oe_o == 3'b000)
        else $error("pin enabled with no route");

    // A taken request is answered once and the answer drops straight away.
    sequence ack_then_drop_s;
        ack_o ##1 !ack_o;
    endsequence
    bus_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && bus_req ##1 ce_i |-> ack_then_drop_s)
        else $error("bus answer not one pulse");
    count_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        ce_i && bus_req && !we_i && bank == ADDR_BANK_TIMER && reg_adr == ADDR_COUNT
        |=> dat_o[7:0] == $past(count_r))
        else $error("count read wrong");
    bound_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        ce_i && bus_req && !we_i && bank == ADDR_BANK_TIMER && reg_adr == ADDR_BOUND
        |=> dat_o[7:0] == $past(bound_r))
        else $error("bound read wrong");
    control_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        ce_i && wr_control
        |=> control_r == $past(dat_i[7:0]))
        else $error("control write lost");
    scale_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        ce_i && wr_scale
        |=> scale_r == $past(dat_i[7:0]))
        else $error("scale write lost");
    bound_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        ce_i && wr_bound
        |=> bound_r == $past(dat_i[7:0]))
        else $error("bound write lost");
    mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        ce_i && wr_mask
        |=> mask_r == $past(dat_i[0]))
        else $error("mask write lost");

    // A change on a source only counts once the last two stages agree.
    sync_agree_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        ce_i && sync_r[0][1] != sync_r[0][2]
        |=> $stable(stable_r[0]))
        else $error("source taken before agreement");
    prescale_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        ce_i && src_tick && !wr_count && pre_r < pre_top
        |=> pre_r == $past(pre_r) + 6'h01)
        else $error("prescaler did not step");
    scaler_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        ce_i && pre_tick && !wr_count && div_r < div_top
        |=> div_r == $past(div_r) + 5'h01)
        else $error("scaler did not step");
    divider_reload_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        ce_i && wr_count
        |=> pre_r == 6'h00 && div_r == 5'h00)
        else $error("dividers not restarted");
    tick_out_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        ce_i && tm_tick
        |=> divided_timer_clock_o)
        else $error("divided clock pulse missed");
    quiet_out_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        ce_i && !tm_tick
        |=> !divided_timer_clock_o)
        else $error("divided clock pulse without tick");

    pwm8_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        ce_i && tm_tick && !wr_count && pwm_mode && !res6 && count_r == TOP_PWM8
        |=> count_r == 8'h00)
        else $error("8-bit wrap wrong");
    pwm_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        ce_i && pwm_mode && count_r > bound_r
        |=> !pin_o.port_a_bit1)
        else $error("pwm not low");
    pwm_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        ce_i && pwm_mode && bound_r >= pwm_top && count_r <= pwm_top
        |=> pin_o.port_a_bit3)
        else $error("full duty dropped");
    period_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        ce_i && !period_evt
        |=> wave_r == $past(wave_r))
        else $error("period wave moved early");

    irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        ce_i && period_evt && mask_r
        |=> irq_o)
        else $error("interrupt not raised");
    irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        ce_i && !mask_r
        |=> !irq_o)
        else $error("masked interrupt seen");
    status_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        ce_i && wr_status && dat_i[0] && !period_evt
        |=> !status_r)
        else $error("status not cleared");

    // A low enable must hold every piece of timer state.
    freeze_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        !ce_i
        |=> $stable(count_r) && $stable(wave_r) && $stable(pin_o) && $stable(ack_o))
        else $error("state moved while frozen");
endmodule

// file: tb/timer8_src_model.sv
// Purpose: Far-side model that drives the timer's external clock sources.
// Assumes: Each source is a free-running square wave slower than clk_i.
// Notes: Source bit b toggles every (9 - b) cycles, so every source has its own rate.
`timescale 1ns/1ns
module timer8_src_model
    import timer8_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Sources
    output clk_sources_t src_o
);
    logic [3:0] cnt_r [6];

    always @(posedge clk_i) begin
        for (int b = 0; b < 6; b++) begin
            if (rst_i || cnt_r[b] == 4'(8 - b)) begin
                cnt_r[b] <= 4'h0;
                src_o[b] <= rst_i ? 1'b0 : ~src_o[b];
            end else begin
                cnt_r[b] <= cnt_r[b] + 4'h1;
            end
        end
    end
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the 8-bit period and PWM timer.
// Assumes: Divided timer ticks and pin levels are sampled together on clk_i.
// Notes: Waveform lengths are counted in ticks, so pipeline latency cancels out.
`timescale 1ns/1ns
module tb
    import timer8_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic dtc;
    logic irq_o;
    clk_sources_t src;
    pin_out_t pin_o;
    pin_out_t pin_oe_o;
    logic [31:0] exp_q [$];
    logic [31:0] seed = 32'h5A36;
    int num_errors = 0;
    int checked = 0;
    int hi;
    int lo;
    int t;
    int e;
    logic [31:0] r;
    int eo [16] = '{0, 480, 48, 60, 40, 34, 30, 26, 0, 0, 0, 0, 0, 0, 0, 0};

    always #5 clk_i = ~clk_i;

    timer8_src_model model (.clk_i(clk_i), .rst_i(rst_i), .src_o(src));
    timer8_period_pwm dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .src_i(src), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .divided_timer_clock_o(dtc), .irq_o(irq_o));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] gv);
        checked++;
        if (gv !== ev) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, ev, gv);
        end
    endtask

    task automatic summarize();
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Entered right after a rising edge; holds the request until ack is sampled.
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            summarize();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] ev);
        exp_q.push_back(ev);
        wb(1'b0, a, 32'h0);
    endtask

    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
            chk("read_data", exp_q.pop_front(), dat_o);
    end

    task automatic tick_gap(output int c);
        c = 0;
        while (dtc !== 1'b1 && c < 3000) begin
            @(posedge clk_i);
            c++;
        end
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (dtc !== 1'b1 && c < 3000);
    endtask

    // Ticks seen while the waveform is high, then while it is low.
    task automatic span(output int h, output int l);
        int n;
        h = 0;
        l = 0;
        n = 0;
        while (pin_o.port_a_bit1 !== 1'b0 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        while (pin_o.port_a_bit1 !== 1'b1 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        while (pin_o.port_a_bit1 === 1'b1 && n < 9000) begin
            h += int'(dtc);
            @(posedge clk_i);
            n++;
        end
        while (pin_o.port_a_bit1 === 1'b0 && n < 9000) begin
            l += int'(dtc);
            @(posedge clk_i);
            n++;
        end
    endtask

    initial begin
        #900000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 7; a++) begin
            rd(5'(a * 4), 32'h0);
        end
        wb(1'b1, 5'h08, 32'hFFFF_FF37);
        rd(5'h08, 32'h0000_0037);
        wb(1'b1, 5'h0C, 32'h0000_00A5);
        rd(5'h0C, 32'h0000_00A5);
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, 5'h00, 32'(p * 4));
            chk("pin_oe", 32'((4'h8 >> p) & 4'h7), 32'(pin_oe_o));
        end
        for (int p = 0; p < 4; p++) begin
            r = rnd() & 32'h1F;
            wb(1'b1, 5'h04, 32'(p * 32) | r);
            wb(1'b1, 5'h00, 32'h0000_0010);
            tick_gap(t);
            tick_gap(t);
            chk("divide", (32'h1 << (2 * p)) * (r + 1), 32'(t));
        end
        r = rnd() & 32'h7;
        wb(1'b1, 5'h04, 32'h0);
        wb(1'b1, 5'h08, r);
        wb(1'b1, 5'h0C, 32'h0);
        wb(1'b1, 5'h00, 32'h0000_0014);
        span(hi, lo);
        chk("period_high", r + 1, 32'(hi));
        chk("period_low", r + 1, 32'(lo));
        ce_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        hi = int'(pin_o.port_a_bit1);
        t = 0;
        repeat (40) begin
            @(posedge clk_i);
            t += int'(pin_o.port_a_bit1 !== 1'(hi));
        end
        ce_i <= 1'b1;
        @(posedge clk_i);
        chk("freeze", 32'h0, 32'(t));
        chk("irq_masked", 32'h0, 32'(irq_o));
        rd(5'h10, 32'h1);
        wb(1'b1, 5'h14, 32'h1);
        chk("irq_on", 32'h1, 32'(irq_o));
        wb(1'b1, 5'h00, 32'h0);
        wb(1'b1, 5'h10, 32'h1);
        rd(5'h10, 32'h0);
        chk("irq_off", 32'h0, 32'(irq_o));
        r = rnd() & 32'hFE;
        wb(1'b1, 5'h08, r);
        wb(1'b1, 5'h00, 32'h0000_0016);
        span(hi, lo);
        chk("pwm8_high", r + 1, 32'(hi));
        chk("pwm8_low", 32'd255 - r, 32'(lo));
        r = rnd() & 32'h3E;
        wb(1'b1, 5'h04, 32'h80);
        wb(1'b1, 5'h08, r);
        span(hi, lo);
        chk("pwm6_high", r + 1, 32'(hi));
        chk("pwm6_low", 32'd63 - r, 32'(lo));
        wb(1'b1, 5'h08, 32'h3F);
        t = 0;
        repeat (200) begin
            @(posedge clk_i);
            t += int'(pin_o.port_a_bit1 === 1'b0);
        end
        chk("pwm6_full", 32'h0, 32'(t));
        wb(1'b1, 5'h04, 32'h0);
        for (int c = 0; c < 16; c++) begin
            wb(1'b1, 5'h00, 32'(c * 16));
            repeat (10) @(posedge clk_i);
            t = 0;
            repeat (480) begin
                @(posedge clk_i);
                t += int'(dtc);
            end
            e = eo[c];
            chk("source_ticks", 32'h1, 32'((e == 0) ? t == 0 : (t >= e - 1 && t <= e + 1)));
        end
        summarize();
    end
endmodule
